// >>> hw/piu_pkg.sv
// shared constants for the priority interrupt unit
package piu_pkg;
   // ------------------------------------------------------------
   // priority levels
   // ------------------------------------------------------------
   localparam logic [2:0] PIU_LVL_TAPE_ACK  = 3'h7;
   localparam logic [2:0] PIU_LVL_BUS_CLEAR = 3'h6;
   localparam logic [2:0] PIU_LVL_POLL_SEND = 3'h5;
   localparam logic [2:0] PIU_LVL_SEC_TALK  = 3'h4;
   localparam logic [3:0] PIU_LVL_SOURCES   = 4'h4;
   localparam logic [3:0] PIU_PEND_RESET    = 4'h0;
   // ------------------------------------------------------------
   // processor bus
   // ------------------------------------------------------------
   localparam int         PIU_WORD_W      = 16;
   localparam int         PIU_ADDR_W      = 16;
   localparam int         PIU_RAM_WORDS   = 512;
   localparam int         PIU_PAGE_WORDS  = 256;
   localparam int         PIU_TAPE_BUF    = 128;
   localparam logic [3:0] PIU_REG_PRIO    = 4'hA;
   localparam logic [3:0] PIU_REG_IO      = 4'hB;
   localparam logic [3:0] PIU_REG_HSK     = 4'hC;
   localparam logic [3:0] PIU_REG_STATUS  = 4'hD;
   // ------------------------------------------------------------
   // clock
   // ------------------------------------------------------------
   localparam int         PIU_CLK_MHZ     = 250;
   localparam int         PIU_UNIT_MHZ    = 4;
   localparam int         PIU_UNIT_DIV    = PIU_CLK_MHZ / PIU_UNIT_MHZ;
   typedef enum logic [2:0] {
      PIU_IDLE    = 3'b001,
      PIU_PENDING = 3'b010,
      PIU_SERVICE = 3'b100
   } piu_state_e;
endpackage

// >>> hw/piu_sel_decode.sv
// processor access target decoder
`timescale 1ns/1ps
module piu_sel_decode (
   // access
   input  wire logic                          cycle_in,
   input  wire logic                          reg_space_in,
   input  wire logic [piu_pkg::PIU_ADDR_W-1:0] addr_in,
   // one-hot selects
   output logic                               sel_ram_out,
   output logic [3:0]                         sel_reg_out
);
   import piu_pkg::*;
   // ------------------------------------------------------------
   // at most one target; none for unmapped register numbers or ram addresses from 512 up
   // ------------------------------------------------------------
   always_comb begin
      sel_ram_out = 1'b0;
      sel_reg_out = 4'h0;
      if (cycle_in && !reg_space_in) begin
         sel_ram_out = (addr_in < 16'(PIU_RAM_WORDS));
      end else if (cycle_in) begin
         case (addr_in)
            {12'h000, PIU_REG_PRIO}:   sel_reg_out = 4'h1;
            {12'h000, PIU_REG_IO}:     sel_reg_out = 4'h2;
            {12'h000, PIU_REG_HSK}:    sel_reg_out = 4'h4;
            {12'h000, PIU_REG_STATUS}: sel_reg_out = 4'h8;
            default:                   sel_reg_out = 4'h0;
         endcase
      end
   end
endmodule

// >>> hw/piu_top.sv
// priority interrupt unit with scratch ram and register decode
// Functional notes
// - interrupt pending is shown only while enabled, by a clocked state machine.
// - no new interrupt is raised during service; arriving requests are latched.
// - after service, pending requests are presented one at a time, highest first.
// - a pending high-level request always goes ahead of low-level ones.
// - the tape word acknowledge is level 7, the only high-level source.
// - bus clear is 6, poll send enable 5, secondary talk 4; 3..0 never reported.
// - register 10 is the priority encoder working with the state machine.
// - each processor access selects at most one target: ram below 512 or register 10..13.
// - ram holds 512 words: 256 scratch plus a double-buffered 128-word tape area.
// - 16-bit words; ram and register cycles; service via register cycles.
// - power-on preset returns the unit and interrupt logic to idle.
// - interrupt logic and processor share one unit clock.
`timescale 1ns/1ps
module piu_top
#(
   parameter int WORD_W = piu_pkg::PIU_WORD_W,
   parameter int ADDR_W = piu_pkg::PIU_ADDR_W
) (
   // clock and preset
   input  wire logic              ref_clk_in,
   input  wire logic              rst_in,
   // request sources (pins, asynchronous)
   input  wire logic              tape_word_acknowledge_in,
   input  wire logic              bus_clear_request_in,
   input  wire logic              serial_poll_send_enable_in,
   input  wire logic              secondary_talk_request_in,
   // control from processor logic
   input  wire logic              int_enable_in,
   input  wire logic              service_done_in,
   // processor memory cycle
   input  wire logic              cycle_in,
   input  wire logic              reg_space_in,
   input  wire logic              write_in,
   input  wire logic [ADDR_W-1:0] addr_in,
   input  wire logic [WORD_W-1:0] wdata_in,
   // answers
   output logic [WORD_W-1:0]      rdata_out,
   output logic                   rvalid_out,
   output logic                   int_pending_out,
   output logic                   in_service_out,
   output logic                   sel_ram_out,
   output logic [3:0]             sel_reg_out
);
   import piu_pkg::*;

   // ------------------------------------------------------------
   // synchronisers: three stages, change taken when 2 and 3 agree
   // ------------------------------------------------------------
   logic [3:0] raw;
   logic [3:0] s1_r, s2_r, s3_r, lvl_r, lvl_nxt, prev_r;
   assign raw = {tape_word_acknowledge_in, bus_clear_request_in,
                 serial_poll_send_enable_in, secondary_talk_request_in};

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         s1_r <= 4'h0;
         s2_r <= 4'h0;
         s3_r <= 4'h0;
      end else begin
         s1_r <= raw;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   always_comb begin
      for (int i = 0; i < 4; i++) begin
         lvl_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : lvl_r[i];
      end
   end

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         lvl_r <= 4'h0;
      end else begin
         lvl_r <= lvl_nxt;
      end
   end

   // previous filtered level for rising-edge detection
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         prev_r <= 4'h0;
      end else begin
         prev_r <= lvl_r;
      end
   end

   // ------------------------------------------------------------
   // decode and encoder read
   // ------------------------------------------------------------
   piu_sel_decode u_dec (
      .cycle_in     (cycle_in),
      .reg_space_in (reg_space_in),
      .addr_in      (addr_in),
      .sel_ram_out  (sel_ram_out),
      .sel_reg_out  (sel_reg_out)
   );

   logic prio_rd;
   assign prio_rd = sel_reg_out[0] && !write_in;

   // pending bit index 3 = level 7 ... index 0 = level 4
   function automatic logic [3:0] piu_top_bit(input logic [3:0] p);
      logic [3:0] r;
      r = 4'h0;
      if (p[3])      r = 4'h8;
      else if (p[2]) r = 4'h4;
      else if (p[1]) r = 4'h2;
      else if (p[0]) r = 4'h1;
      return r;
   endfunction

   function automatic logic [2:0] piu_code(input logic [3:0] onehot);
      logic [2:0] c;
      c = 3'h0;
      case (onehot)
         4'h8:    c = PIU_LVL_TAPE_ACK;
         4'h4:    c = PIU_LVL_BUS_CLEAR;
         4'h2:    c = PIU_LVL_POLL_SEND;
         4'h1:    c = PIU_LVL_SEC_TALK;
         default: c = 3'h0;
      endcase
      return c;
   endfunction

   // ------------------------------------------------------------
   // pending latches: rising edges set, encoder read clears
   // ------------------------------------------------------------
   logic [3:0] pend_r, top, set_ev, clr_ev;
   assign top    = piu_top_bit(pend_r);
   assign set_ev = lvl_r & ~prev_r;
   assign clr_ev = prio_rd ? top : 4'h0;

   // a pin held high latches once; a pulse under two clocks may be missed
   // set wins over clear so nothing arriving during service is lost
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         pend_r <= PIU_PEND_RESET;
      end else begin
         pend_r <= (pend_r & ~clr_ev) | set_ev;
      end
   end

   // ------------------------------------------------------------
   // interrupt state machine
   // ------------------------------------------------------------
   piu_state_e st_r, st_nxt;
   always_comb begin
      st_nxt = st_r;
      case (st_r)
         PIU_IDLE: begin
            if (int_enable_in && pend_r != 4'h0) st_nxt = PIU_PENDING;
         end
         PIU_PENDING: begin
            if (prio_rd)             st_nxt = PIU_SERVICE;
            else if (!int_enable_in) st_nxt = PIU_IDLE;
         end
         PIU_SERVICE: begin
            if (service_done_in) st_nxt = PIU_IDLE;
         end
         default: st_nxt = PIU_IDLE;
      endcase
   end

   // logic and processor share this single clock, so no crossing here
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         st_r <= PIU_IDLE;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign int_pending_out = (st_r == PIU_PENDING) && int_enable_in;
   assign in_service_out  = (st_r == PIU_SERVICE);

   // ------------------------------------------------------------
   // scratch and tape buffer ram
   // ------------------------------------------------------------
   // low half is base-page scratch, high half the two 128-word tape buffers
   logic [WORD_W-1:0] ram [PIU_RAM_WORDS];
   logic [8:0]        ram_a;
   assign ram_a = addr_in[8:0];

   always_ff @(posedge ref_clk_in) begin
      if (sel_ram_out && write_in) begin
         ram[ram_a] <= wdata_in;
      end
   end

   // ------------------------------------------------------------
   // read data: one cycle after the access
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         rvalid_out <= 1'b0;
      end else begin
         rvalid_out <= cycle_in && !write_in;
      end
   end

   // registers 11..13 belong to other blocks and read zero here
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         rdata_out <= '0;
      end else begin
         if (sel_ram_out && !write_in) begin
            rdata_out <= ram[ram_a];
         end else if (prio_rd) begin
            rdata_out <= {{(WORD_W-3){1'b0}}, piu_code(top)};
         end else begin
            rdata_out <= '0;
         end
      end
   end
endmodule

// >>> testbench/piu_monitor.sv
// bound checker on the priority interrupt unit ports
`timescale 1ns/1ps
module piu_monitor (
   // clock and preset
   input wire logic        ref_clk_in,
   input wire logic        rst_in,
   // processor side
   input wire logic        int_enable_in,
   input wire logic        service_done_in,
   input wire logic        cycle_in,
   input wire logic        reg_space_in,
   input wire logic        write_in,
   input wire logic [15:0] addr_in,
   // answers
   input wire logic [15:0] rdata_out,
   input wire logic        rvalid_out,
   input wire logic        int_pending_out,
   input wire logic        in_service_out,
   input wire logic        sel_ram_out,
   input wire logic [3:0]  sel_reg_out
);
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (rst_in);
   wire logic rd10 = cycle_in && reg_space_in && !write_in && addr_in == 16'h000A;
   a_pend_needs_en: assert property (int_pending_out |-> int_enable_in)
      else $error("pending while disabled");
   a_no_nesting: assert property (in_service_out |-> !int_pending_out)
      else $error("pending during service");
   a_read_starts_svc: assert property (rd10 && int_pending_out |=>
      in_service_out && rvalid_out && rdata_out[2:0] != 3'h0) else $error("bad take");
   a_code_legal: assert property (rvalid_out && rdata_out != 16'h0000 && $past(rd10) |->
      rdata_out[15:2] == 14'h0001) else $error("illegal level code");
   a_read_answer: assert property (rd10 |=> rvalid_out)
      else $error("no encoder answer");
   a_done_ends: assert property (in_service_out && service_done_in |=>
      !in_service_out && !int_pending_out) else $error("service not ended");
   a_service_holds: assert property (in_service_out && !service_done_in |=>
      in_service_out && !int_pending_out) else $error("service left early");
   a_preset_idle: assert property ($fell(rst_in) |->
      !int_pending_out && !in_service_out && !rvalid_out) else $error("not idle");
   a_reg_select: assert property (cycle_in && reg_space_in && addr_in == 16'h000A |->
      sel_reg_out == 4'h1 && !sel_ram_out) else $error("bad register select");
   a_ram_select: assert property (cycle_in && !reg_space_in && addr_in < 16'h0200 |->
      sel_ram_out && sel_reg_out == 4'h0) else $error("bad ram select");
endmodule
bind piu_top piu_monitor mon (
   .ref_clk_in(ref_clk_in), .rst_in(rst_in), .int_enable_in(int_enable_in),
   .service_done_in(service_done_in), .cycle_in(cycle_in), .reg_space_in(reg_space_in),
   .write_in(write_in), .addr_in(addr_in), .rdata_out(rdata_out), .rvalid_out(rvalid_out),
   .int_pending_out(int_pending_out), .in_service_out(in_service_out),
   .sel_ram_out(sel_ram_out), .sel_reg_out(sel_reg_out)
);

// >>> testbench/piu_cpu_model.sv
// processor model: memory cycles and end-of-service strobe
`timescale 1ns/1ps
module piu_cpu_model (
   // clock and answer
   input  wire logic        ref_clk_in,
   input  wire logic [15:0] rdata_in,
   // memory cycle
   output logic             cycle_out,
   output logic             reg_space_out,
   output logic             write_out,
   output logic [15:0]      addr_out,
   output logic [15:0]      wdata_out,
   output logic             service_done_out
);
   initial begin
      cycle_out = 1'b0;
      reg_space_out = 1'b0;
      write_out = 1'b0;
      addr_out = 16'h0000;
      wdata_out = 16'h0000;
      service_done_out = 1'b0;
   end
   task automatic access(input logic rs, input logic w, input logic [15:0] a,
                         input logic [15:0] d, output logic [15:0] q);
      @(negedge ref_clk_in);
      cycle_out = 1'b1;
      reg_space_out = rs;
      write_out = w;
      addr_out = a;
      wdata_out = d;
      @(negedge ref_clk_in);
      q = rdata_in;
      cycle_out = 1'b0;
      // flipped so a stale address never looks valid
      addr_out = ~a;
      wdata_out = ~d;
   endtask
   task automatic end_service(input int gap);
      repeat (gap) @(negedge ref_clk_in);
      service_done_out = 1'b1;
      @(negedge ref_clk_in);
      service_done_out = 1'b0;
   endtask
endmodule

// >>> testbench/piu_tb_top.sv
// self-checking bench for the priority interrupt unit
`timescale 1ns/1ps
module piu_tb_top;
   import piu_pkg::*;
   logic        ref_clk_in = 1'b0;
   logic        rst_in = 1'b1;
   logic        tape = 1'b0;
   logic        clr = 1'b0;
   logic        poll = 1'b0;
   logic        talk = 1'b0;
   logic        en = 1'b1;
   logic        cyc, rsp, wr, done, pend, svc;
   logic [15:0] addr, wd, rd;
   int          failures = 0;
   int          check_count = 0;
   always #2 ref_clk_in = ~ref_clk_in;
   piu_top dut (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .tape_word_acknowledge_in(tape),
      .bus_clear_request_in(clr), .serial_poll_send_enable_in(poll),
      .secondary_talk_request_in(talk), .int_enable_in(en), .service_done_in(done),
      .cycle_in(cyc), .reg_space_in(rsp), .write_in(wr), .addr_in(addr), .wdata_in(wd),
      .rdata_out(rd), .rvalid_out(), .int_pending_out(pend), .in_service_out(svc),
      .sel_ram_out(), .sel_reg_out());
   piu_cpu_model cpu (.ref_clk_in(ref_clk_in), .rdata_in(rd), .cycle_out(cyc),
      .reg_space_out(rsp), .write_out(wr), .addr_out(addr), .wdata_out(wd),
      .service_done_out(done));
   task automatic print_verdict;
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wait_pend;
      int n = 0;
      while (pend !== 1'b1 && n < 20) begin
         @(negedge ref_clk_in);
         n++;
      end
      if (pend !== 1'b1) begin
         failures++;
         $display("[ERR] %0t no interrupt", $time);
         print_verdict();
      end
   endtask
   task automatic rd10(output logic [15:0] q);
      cpu.access(1'b1, 1'b0, 16'h000A, 16'h0000, q);
   endtask
   task automatic s_decode;
      logic [15:0] q;
      cpu.access(1'b0, 1'b1, 16'h01FF, 16'hA5C3, q);
      cpu.access(1'b0, 1'b0, 16'h01FF, 16'h0000, q);
      check(q, 16'hA5C3);
      cpu.access(1'b0, 1'b0, 16'h0200, 16'h0000, q);
      check(q, 16'h0000);
      cpu.access(1'b1, 1'b0, 16'h000B, 16'h0000, q);
      check(q, 16'h0000);
      cpu.access(1'b1, 1'b1, 16'h000A, 16'h0007, q);
      rd10(q);
      check(q, 16'h0000);
   endtask
   task automatic s_prio;
      logic [15:0] q;
      logic [2:0]  lv[3] = '{PIU_LVL_TAPE_ACK, PIU_LVL_POLL_SEND, PIU_LVL_SEC_TALK};
      {clr, poll, talk} = 3'h7;
      wait_pend();
      rd10(q);
      check(q, {13'h0, PIU_LVL_BUS_CLEAR});
      check(svc, 1'b1);
      tape = 1'b1;
      repeat (12) @(negedge ref_clk_in);
      check(pend, 1'b0);
      cpu.end_service(5);
      foreach (lv[i]) begin
         wait_pend();
         rd10(q);
         check(q, {13'h0, lv[i]});
         cpu.end_service(0);
      end
      {tape, clr, poll, talk} = 4'h0;
      rd10(q);
      check(q, 16'h0000);
   endtask
   task automatic s_enable;
      logic [15:0] q;
      en = 1'b0;
      tape = 1'b1;
      repeat (10) @(negedge ref_clk_in);
      check(pend, 1'b0);
      rd10(q);
      check(q, {13'h0, PIU_LVL_TAPE_ACK});
      tape = 1'b0;
      en = 1'b1;
      repeat (4) @(negedge ref_clk_in);
      check(pend, 1'b0);
      tape = 1'b1;
      wait_pend();
      en = 1'b0;
      repeat (2) @(negedge ref_clk_in);
      en = 1'b1;
      check(pend, 1'b0);
      wait_pend();
      rd10(q);
      check(q, {13'h0, PIU_LVL_TAPE_ACK});
      cpu.end_service(0);
      tape = 1'b0;
      repeat (4) @(negedge ref_clk_in);
   endtask
   task automatic s_preset;
      logic [15:0] q;
      tape = 1'b1;
      wait_pend();
      rst_in = 1'b1;
      tape = 1'b0;
      repeat (3) @(negedge ref_clk_in);
      check({pend, svc}, 2'b00);
      rst_in = 1'b0;
      rd10(q);
      check(q, 16'h0000);
   endtask
   initial begin
      repeat (12) @(negedge ref_clk_in);
      rst_in = 1'b0;
      s_decode();
      s_prio();
      s_enable();
      s_preset();
      print_verdict();
   end
endmodule
